// ---- logic/qec_pkg.sv ----
package qec_pkg;
	// ==========================================================
	// sizes
	localparam int AXES        = 4;
	localparam int CNT_W       = 24;
	localparam int BYTE_W      = 8;
	localparam int ADDR_W      = 12;
	localparam int FILT_STAGES = 4;
	localparam int IN_PER_AXIS = 3;
	localparam int IN_PHASE_A  = 0;
	localparam int IN_PHASE_B  = 1;
	localparam int IN_INDEX    = 2;

	// ==========================================================
	// sample clock for the input filters
	localparam int unsigned SYS_CLK_HZ     = 20_000_000;
	localparam int unsigned SAMPLE_MAX_HZ  = 10_000_000;
	localparam int unsigned SAMPLE_DIV_MIN = SYS_CLK_HZ / SAMPLE_MAX_HZ;
	localparam int          RATE_SEL_W     = 3;
	localparam int          DIV_W          = 6;
	localparam logic [RATE_SEL_W-1:0] RATE_SEL_SLOWEST = 3'h4;

	// ==========================================================
	// base address and indirect map
	localparam logic [3:0]        BASE_HI_2XX     = 4'h2;
	localparam logic [3:0]        BASE_HI_3XX     = 4'h3;
	localparam logic [BYTE_W-1:0] IDX_AXIS_LAST   = 8'h07;
	localparam logic [BYTE_W-1:0] IDX_GLOBAL_LOAD = 8'h08;
	localparam logic [BYTE_W-1:0] IDX_GLOBAL_CMD  = 8'h09;
	localparam logic [BYTE_W-1:0] IDX_IRQ_LOW     = 8'h0a;
	localparam logic [BYTE_W-1:0] IDX_IRQ_HIGH    = 8'h0b;
	localparam logic [1:0]        BYTE_PTR_LAST   = 2'h2;
	localparam logic [CNT_W-1:0]  CNT_MAX         = 24'hffffff;
	localparam logic [CNT_W-1:0]  CNT_ZERO        = 24'h000000;

	// ==========================================================
	// command byte sequence and counting modes
	typedef enum logic [1:0] {
		CMD_MASTER = 2'b00,
		CMD_INPUT  = 2'b01,
		CMD_OUTCNT = 2'b10,
		CMD_DECODE = 2'b11
	} qec_cmd_t;

	typedef enum logic [1:0] {
		MODE_QUAD = 2'b00,
		MODE_PDIR = 2'b01,
		MODE_UPDN = 2'b10
	} qec_mode_t;

	// ==========================================================
	// bit positions inside setup bytes and the flag word
	localparam int MST_CAPTURE    = 0;
	localparam int MST_RESET      = 1;
	localparam int MST_LOAD       = 2;
	localparam int MST_BCD        = 3;
	localparam int MST_CLR_FLAGS  = 4;
	localparam int IN_IDX_GATE    = 4;
	localparam int IN_IDX_CAPTURE = 5;
	localparam int IN_IDX_EN      = 6;
	localparam int OC_EN_LO       = 4;
	localparam int FLG_CARRY      = 0;
	localparam int FLG_BORROW     = 1;
	localparam int FLG_CMP        = 2;
	localparam int FLG_INDEX      = 3;
	localparam int FLG_UP         = 4;
	localparam int FLG_EVT_W      = 4;
endpackage

// ---- logic/qec_filter.sv ----
`timescale 1ns/1ps
module qec_filter
	import qec_pkg::*;
(
	input  wire logic clk_i,     // system clock
	input  wire logic sys_rst_i, // synchronous reset, active high
	input  wire logic tick_i,    // sample clock enable pulse
	input  wire logic raw_i,     // unfiltered input
	output logic      filt_o     // conditioned input
);
	logic [FILT_STAGES-1:0] shift_r;
	logic [FILT_STAGES-1:0] shift_nxt;
	logic                   filt_r;
	logic                   filt_nxt;

	// ==========================================================
	// four samples must agree before the output moves; spikes shorter
	// than the window never reach the counter
	always_comb begin
		shift_nxt = shift_r;
		filt_nxt  = filt_r;
		if (tick_i) begin
			shift_nxt = {shift_r[FILT_STAGES-2:0], raw_i};
			if (&shift_r)
				filt_nxt = 1'b1;
			else if (~|shift_r)
				filt_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			shift_r <= '0;
			filt_r  <= 1'b0;
		end else begin
			shift_r <= shift_nxt;
			filt_r  <= filt_nxt;
		end
	end

	assign filt_o = filt_r;
endmodule

// ---- logic/qec_top.sv ----
// Behaviour
// - every phase A, phase B and index input passes a four-stage digital filter
// - filters sample on one strap-selected clock, five rates, fastest 10 MHz
// - accepts about 333 kHz per phase in quadrature, 1.25 MHz in count modes
// - each axis has its own 24-bit counter fed by its filtered inputs
// - modes: quadrature, pulse plus direction, separate up and down pulses
// - count read back as plain binary or as BCD, as configured
// - latch on command or index; or load counter from load value on index
// - maskable requests on index, overflow or underflow, and compare match
// - adjacent counters chain so carry or borrow feeds the next axis
// - upper four base address bits from strap: 2xx or 3xx range
// - lower eight bits from two switches; odd low nibble settings unusable
// - two ports: even holds indirect address, odd carries register data
// - indirect address holds across data accesses until rewritten
// - data write at even axis address fills load value byte, advances pointer
// - data read at even axis address returns latch byte, advances pointer
// - odd axis address: write goes to command port, read gives flag word
// - 08 writes all load values, 09 all command ports; reads invalid
// - 0A and 0B reach the irq controller low and high ports
// - input bit 4 low: index resets counter when bit 5 is high; high: index gates phases
// - input bit 5 low: index loads counter; high: index captures latch
// - sample rates 0.625 to 10 MHz, slowest is the default
`timescale 1ns/1ps
module qec_top
	import qec_pkg::*;
(
	input  wire logic                        clk_i,                   // 20 MHz clock
	input  wire logic                        sys_rst_i,               // sync reset, high
	input  wire logic [ADDR_W-1:0]           io_addr_i,               // I/O address
	input  wire logic                        io_wr_i,                 // write strobe, 1 cycle
	input  wire logic                        io_rd_i,                 // read strobe, 1 cycle
	input  wire logic [BYTE_W-1:0]           io_wdata_i,              // write data
	output logic      [BYTE_W-1:0]           io_rdata_o,              // read data
	output logic                             io_rack_o,               // read data valid pulse
	input  wire logic                        base_high_nibble_strap_i, // 0: 2xx, 1: 3xx
	input  wire logic [3:0]                  base_mid_nibble_switch_i, // address bits 7:4
	input  wire logic [3:0]                  base_low_nibble_switch_i, // address bits 3:0
	input  wire logic [RATE_SEL_W-1:0]       sample_rate_strap_i,     // 0 fastest, 4 slowest
	input  wire logic [AXES-2:0]             cascade_strap_i,         // bit n: axis n to n+1
	input  wire logic [AXES*IN_PER_AXIS-1:0] enc_in_i,                // A,B,index per axis
	output logic                             irq_ctl_wr_o,            // controller write pulse
	output logic                             irq_ctl_rd_o,            // controller read pulse
	output logic                             irq_ctl_a0_o,            // low 0, high 1
	output logic      [BYTE_W-1:0]           irq_ctl_wdata_o,         // controller write data
	input  wire logic [BYTE_W-1:0]           irq_ctl_rdata_i,         // controller read data
	output logic      [AXES-1:0]             axis_irq_o               // per-axis request
);
	// ==========================================================
	// filter sample clock: divide by 2 << strap, so 10 MHz down to 0.625 MHz
	logic [DIV_W-1:0]      div_r, div_nxt;
	logic                  tick_r, tick_nxt;
	logic [RATE_SEL_W-1:0] rate_r, rate_nxt;
	logic [DIV_W-1:0]      div_last;

	always_comb begin
		rate_nxt = (sample_rate_strap_i > RATE_SEL_SLOWEST) ? RATE_SEL_SLOWEST
			: sample_rate_strap_i;
		div_last = DIV_W'((SAMPLE_DIV_MIN << rate_r) - 1);
		div_nxt  = (div_r >= div_last) ? '0 : div_r + 1'b1;
		tick_nxt = (div_r >= div_last);
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			div_r  <= '0;
			tick_r <= 1'b0;
			rate_r <= RATE_SEL_SLOWEST;
		end else begin
			div_r  <= div_nxt;
			tick_r <= tick_nxt;
			rate_r <= rate_nxt;
		end
	end

	// ==========================================================
	// input conditioning, one filter per pin
	logic [AXES*IN_PER_AXIS-1:0] filt;

	genvar gi;
	generate
		for (gi = 0; gi < AXES*IN_PER_AXIS; gi++) begin : g_filt
			qec_filter u_filt (
				.clk_i     (clk_i),
				.sys_rst_i (sys_rst_i),
				.tick_i    (tick_r),
				.raw_i     (enc_in_i[gi]),
				.filt_o    (filt[gi])
			);
		end
	endgenerate

	// ==========================================================
	// BCD conversion of a latched count; values past 999999 wrap
	function automatic logic [CNT_W-1:0] to_bcd(input logic [CNT_W-1:0] bin);
		logic [CNT_W-1:0] bcd;
		bcd = '0;
		for (int i = CNT_W-1; i >= 0; i--) begin
			for (int d = 0; d < CNT_W/4; d++)
				if (bcd[d*4 +: 4] > 4'h4)
					bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
			bcd = {bcd[CNT_W-2:0], bin[i]};
		end
		return bcd;
	endfunction

	// ==========================================================
	// host port, indirect address, per-axis registers and counters
	logic [BYTE_W-1:0] idx_r, idx_nxt;
	logic [BYTE_W-1:0] rdata_r, rdata_nxt;
	logic              rack_r, rack_nxt;
	logic              icw_r, icw_nxt, icr_r, icr_nxt, ica0_r, ica0_nxt;
	logic [BYTE_W-1:0] icd_r, icd_nxt;
	logic [AXES-1:0]   irq_r, irq_nxt;

	logic [CNT_W-1:0]  cnt_r   [AXES];
	logic [CNT_W-1:0]  cnt_nxt [AXES];
	logic [CNT_W-1:0]  load_r  [AXES];
	logic [CNT_W-1:0]  load_nxt[AXES];
	logic [CNT_W-1:0]  latch_r [AXES];
	logic [CNT_W-1:0]  latch_nxt[AXES];
	logic [BYTE_W-1:0] mst_r   [AXES];
	logic [BYTE_W-1:0] mst_nxt [AXES];
	logic [BYTE_W-1:0] inp_r   [AXES];
	logic [BYTE_W-1:0] inp_nxt [AXES];
	logic [BYTE_W-1:0] occ_r   [AXES];
	logic [BYTE_W-1:0] occ_nxt [AXES];
	logic [BYTE_W-1:0] dec_r   [AXES];
	logic [BYTE_W-1:0] dec_nxt [AXES];
	logic [BYTE_W-1:0] flg_r   [AXES];
	logic [BYTE_W-1:0] flg_nxt [AXES];
	qec_cmd_t          seq_r   [AXES];
	qec_cmd_t          seq_nxt [AXES];
	logic [1:0]        ptr_r   [AXES];
	logic [1:0]        ptr_nxt [AXES];
	logic [AXES-1:0]   pa_r, pb_r, pi_r;
	logic [AXES-1:0]   cy_r, cy_nxt, bw_r, bw_nxt;

	logic [ADDR_W-1:0] base;
	logic              hit, wr_idx, wr_dat, rd_dat;

	// base from strap and switches; bit 0 forced even because two ports are used
	always_comb begin
		base = {base_high_nibble_strap_i ? BASE_HI_3XX : BASE_HI_2XX,
			base_mid_nibble_switch_i, base_low_nibble_switch_i[3:1], 1'b0};
		hit    = (io_addr_i[ADDR_W-1:1] == base[ADDR_W-1:1]);
		wr_idx = hit & io_wr_i & ~io_addr_i[0];
		wr_dat = hit & io_wr_i & io_addr_i[0];
		rd_dat = hit & io_rd_i & io_addr_i[0];
	end

	// one combinational pass per axis; host writes override counting in a cycle
	always_comb begin
		logic            sel_ev, sel_od, a_q, b_q, i_q, up, dn, gate_ok, idx_edge;
		logic [CNT_W-1:0] shown;
		sel_ev = 1'b0; sel_od = 1'b0; a_q = 1'b0; b_q = 1'b0; i_q = 1'b0;
		up = 1'b0; dn = 1'b0; gate_ok = 1'b0; idx_edge = 1'b0; shown = '0;
		idx_nxt   = wr_idx ? io_wdata_i : idx_r;
		rdata_nxt = rdata_r;
		rack_nxt  = rd_dat;
		icw_nxt   = 1'b0;
		icr_nxt   = 1'b0;
		// port select follows the index, so the controller already shows the
		// right port when a data read samples its bus in the strobe cycle
		ica0_nxt  = (idx_nxt == IDX_IRQ_HIGH);
		icd_nxt   = icd_r;
		if ((wr_dat | rd_dat) & (idx_r == IDX_IRQ_LOW | idx_r == IDX_IRQ_HIGH)) begin
			icw_nxt  = wr_dat;
			icr_nxt  = rd_dat;
			icd_nxt  = io_wdata_i;
		end
		if (rd_dat & (idx_r > IDX_AXIS_LAST))
			rdata_nxt = (idx_r == IDX_IRQ_LOW | idx_r == IDX_IRQ_HIGH) ? irq_ctl_rdata_i
				: '0;
		if (hit & io_rd_i & ~io_addr_i[0])
			rdata_nxt = idx_r;
		rack_nxt = hit & io_rd_i;

		for (int a = 0; a < AXES; a++) begin
			cnt_nxt[a]   = cnt_r[a];
			load_nxt[a]  = load_r[a];
			latch_nxt[a] = latch_r[a];
			mst_nxt[a]   = mst_r[a];
			inp_nxt[a]   = inp_r[a];
			occ_nxt[a]   = occ_r[a];
			dec_nxt[a]   = dec_r[a];
			flg_nxt[a]   = flg_r[a];
			seq_nxt[a]   = seq_r[a];
			ptr_nxt[a]   = ptr_r[a];
			cy_nxt[a]    = 1'b0;
			bw_nxt[a]    = 1'b0;

			// counting from filtered inputs
			a_q = filt[a*IN_PER_AXIS + IN_PHASE_A];
			b_q = filt[a*IN_PER_AXIS + IN_PHASE_B];
			i_q = filt[a*IN_PER_AXIS + IN_INDEX];
			up = 1'b0;
			dn = 1'b0;
			gate_ok = ~(inp_r[a][IN_IDX_EN] & inp_r[a][IN_IDX_GATE]) | i_q;
			if (gate_ok) begin
				case (qec_mode_t'(dec_r[a][1:0]))
					MODE_QUAD: begin
						if ((a_q ^ pa_r[a]) & ~(b_q ^ pb_r[a])) begin
							up = (a_q != b_q);
							dn = (a_q == b_q);
						end else if ((b_q ^ pb_r[a]) & ~(a_q ^ pa_r[a])) begin
							up = (a_q == b_q);
							dn = (a_q != b_q);
						end
					end
					MODE_PDIR: begin
						up = a_q & ~pa_r[a] & b_q;
						dn = a_q & ~pa_r[a] & ~b_q;
					end
					MODE_UPDN: begin
						up = a_q & ~pa_r[a];
						dn = b_q & ~pb_r[a];
					end
					default: begin
						up = 1'b0;
						dn = 1'b0;
					end
				endcase
			end
			if (a > 0) begin
				if (cascade_strap_i[a-1]) begin
					up = up | cy_r[a-1];
					dn = dn | bw_r[a-1];
				end
			end
			if (up & ~dn) begin
				cnt_nxt[a] = cnt_r[a] + 1'b1;
				cy_nxt[a]  = (cnt_r[a] == CNT_MAX);
				flg_nxt[a][FLG_UP] = 1'b1;
			end else if (dn & ~up) begin
				cnt_nxt[a] = cnt_r[a] - 1'b1;
				bw_nxt[a]  = (cnt_r[a] == CNT_ZERO);
				flg_nxt[a][FLG_UP] = 1'b0;
			end

			// index actions on a valid index edge
			idx_edge = i_q & ~pi_r[a] & inp_r[a][IN_IDX_EN];
			if (idx_edge) begin
				if (~inp_r[a][IN_IDX_GATE])
					cnt_nxt[a] = CNT_ZERO;
				if (inp_r[a][IN_IDX_CAPTURE])
					latch_nxt[a] = cnt_r[a];
				else
					cnt_nxt[a] = load_r[a];
			end

			// host access: own addresses and global ones
			sel_ev = (idx_r == BYTE_W'(2*a));
			sel_od = (idx_r == BYTE_W'(2*a + 1));
			if (wr_dat & (sel_ev | idx_r == IDX_GLOBAL_LOAD)) begin
				load_nxt[a][{ptr_r[a], 3'b000} +: BYTE_W] = io_wdata_i;
				ptr_nxt[a] = (ptr_r[a] == BYTE_PTR_LAST) ? 2'h0 : ptr_r[a] + 1'b1;
			end
			if (rd_dat & sel_ev) begin
				shown = mst_r[a][MST_BCD] ? to_bcd(latch_r[a]) : latch_r[a];
				rdata_nxt  = shown[{ptr_r[a], 3'b000} +: BYTE_W];
				ptr_nxt[a] = (ptr_r[a] == BYTE_PTR_LAST) ? 2'h0 : ptr_r[a] + 1'b1;
			end
			if (rd_dat & sel_od) begin
				rdata_nxt  = flg_r[a];
				flg_nxt[a][FLG_EVT_W-1:0] = '0;
			end
			if (wr_dat & (sel_od | idx_r == IDX_GLOBAL_CMD)) begin
				ptr_nxt[a] = 2'h0;
				seq_nxt[a] = qec_cmd_t'(seq_r[a] + 1'b1);
				case (seq_r[a])
					CMD_MASTER: begin
						mst_nxt[a] = io_wdata_i;
						if (io_wdata_i[MST_RESET])
							cnt_nxt[a] = CNT_ZERO;
						if (io_wdata_i[MST_LOAD])
							cnt_nxt[a] = load_r[a];
						if (io_wdata_i[MST_CAPTURE])
							latch_nxt[a] = cnt_r[a];
						if (io_wdata_i[MST_CLR_FLAGS])
							flg_nxt[a][FLG_EVT_W-1:0] = '0;
					end
					CMD_INPUT:  inp_nxt[a] = io_wdata_i;
					CMD_OUTCNT: occ_nxt[a] = io_wdata_i;
					CMD_DECODE: dec_nxt[a] = io_wdata_i;
					default:    seq_nxt[a] = CMD_MASTER;
				endcase
			end

			// sticky event flags; a new event wins over a clear in the same cycle
			if (cy_nxt[a])
				flg_nxt[a][FLG_CARRY] = 1'b1;
			if (bw_nxt[a])
				flg_nxt[a][FLG_BORROW] = 1'b1;
			if (idx_edge)
				flg_nxt[a][FLG_INDEX] = 1'b1;
			if ((cnt_nxt[a] != cnt_r[a]) & (cnt_nxt[a] == load_r[a]))
				flg_nxt[a][FLG_CMP] = 1'b1;
			irq_nxt[a] = |(flg_r[a][FLG_EVT_W-1:0] & occ_r[a][OC_EN_LO +: FLG_EVT_W]);
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			idx_r   <= '0;
			rdata_r <= '0;
			rack_r  <= 1'b0;
			icw_r   <= 1'b0;
			icr_r   <= 1'b0;
			ica0_r  <= 1'b0;
			icd_r   <= '0;
			irq_r   <= '0;
			pa_r    <= '0;
			pb_r    <= '0;
			pi_r    <= '0;
			cy_r    <= '0;
			bw_r    <= '0;
			for (int a = 0; a < AXES; a++) begin
				cnt_r[a]   <= '0;
				load_r[a]  <= '0;
				latch_r[a] <= '0;
				mst_r[a]   <= '0;
				inp_r[a]   <= '0;
				occ_r[a]   <= '0;
				dec_r[a]   <= '0;
				flg_r[a]   <= '0;
				seq_r[a]   <= CMD_MASTER;
				ptr_r[a]   <= '0;
			end
		end else begin
			idx_r   <= idx_nxt;
			rdata_r <= rdata_nxt;
			rack_r  <= rack_nxt;
			icw_r   <= icw_nxt;
			icr_r   <= icr_nxt;
			ica0_r  <= ica0_nxt;
			icd_r   <= icd_nxt;
			irq_r   <= irq_nxt;
			cy_r    <= cy_nxt;
			bw_r    <= bw_nxt;
			for (int a = 0; a < AXES; a++) begin
				pa_r[a]    <= filt[a*IN_PER_AXIS + IN_PHASE_A];
				pb_r[a]    <= filt[a*IN_PER_AXIS + IN_PHASE_B];
				pi_r[a]    <= filt[a*IN_PER_AXIS + IN_INDEX];
				cnt_r[a]   <= cnt_nxt[a];
				load_r[a]  <= load_nxt[a];
				latch_r[a] <= latch_nxt[a];
				mst_r[a]   <= mst_nxt[a];
				inp_r[a]   <= inp_nxt[a];
				occ_r[a]   <= occ_nxt[a];
				dec_r[a]   <= dec_nxt[a];
				flg_r[a]   <= flg_nxt[a];
				seq_r[a]   <= seq_nxt[a];
				ptr_r[a]   <= ptr_nxt[a];
			end
		end
	end

	// every output straight from a flip-flop
	assign io_rdata_o      = rdata_r;
	assign io_rack_o       = rack_r;
	assign irq_ctl_wr_o    = icw_r;
	assign irq_ctl_rd_o    = icr_r;
	assign irq_ctl_a0_o    = ica0_r;
	assign irq_ctl_wdata_o = icd_r;
	assign axis_irq_o      = irq_r;
endmodule

// ---- verif/qec_irqctl_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// stand-in for the on-board interrupt controller's two ports
module qec_irqctl_model
	import qec_pkg::*;
(
	input  wire logic              clk_i,     // system clock
	input  wire logic              sys_rst_i, // sync reset
	input  wire logic              wr_i,      // write pulse
	input  wire logic              a0_i,      // port select
	input  wire logic [BYTE_W-1:0] wdata_i,   // write data
	output logic      [BYTE_W-1:0] rdata_o    // read data
);
	logic [BYTE_W-1:0] low_r;
	logic [BYTE_W-1:0] high_r;

	// each port keeps what was last written to it
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			low_r  <= 8'h00;
			high_r <= 8'h00;
		end else if (wr_i && !a0_i) begin
			low_r <= wdata_i;
		end else if (wr_i) begin
			high_r <= wdata_i;
		end
	end

	// read data follows the select line, no hold beyond it
	assign rdata_o = a0_i ? high_r : low_r;
endmodule

// ---- verif/qec_asserts.sv ----
`timescale 1ns/1ps
// ==========================================================
// port-level checker for the indirect register port
module qec_asserts
	import qec_pkg::*;
(
	input wire logic              clk_i,                    // clock
	input wire logic              sys_rst_i,                // reset
	input wire logic [ADDR_W-1:0] io_addr_i,                // address
	input wire logic              io_wr_i,                  // write
	input wire logic              io_rd_i,                  // read
	input wire logic [BYTE_W-1:0] io_wdata_i,               // wdata
	input wire logic [BYTE_W-1:0] io_rdata_o,               // rdata
	input wire logic              io_rack_o,                // ack
	input wire logic              base_high_nibble_strap_i, // strap
	input wire logic [3:0]        base_mid_nibble_switch_i, // switch
	input wire logic [3:0]        base_low_nibble_switch_i, // switch
	input wire logic              irq_ctl_wr_o,             // ctl wr
	input wire logic              irq_ctl_rd_o,             // ctl rd
	input wire logic              irq_ctl_a0_o,             // ctl a0
	input wire logic [BYTE_W-1:0] irq_ctl_wdata_o,          // ctl wdata
	input wire logic [BYTE_W-1:0] irq_ctl_rdata_i,          // ctl rdata
	input wire logic [AXES-1:0]   axis_irq_o                // requests
);
	logic [10:0]       base_w;
	logic              rdhit_w;
	logic              wrhit_w;
	logic              rd_even_w;
	logic              ctl_sel_w;
	logic [BYTE_W-1:0] idx_r;

	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// decoded hits; bit 0 of the low switch is ignored
	assign base_w    = {(base_high_nibble_strap_i ? BASE_HI_3XX : BASE_HI_2XX),
		base_mid_nibble_switch_i, base_low_nibble_switch_i[3:1]};
	assign rdhit_w   = io_rd_i && (io_addr_i[ADDR_W-1:1] == base_w);
	assign wrhit_w   = io_wr_i && (io_addr_i[ADDR_W-1:1] == base_w);
	assign rd_even_w = rdhit_w && !io_addr_i[0];
	assign ctl_sel_w = io_addr_i[0] && (idx_r == IDX_IRQ_LOW || idx_r == IDX_IRQ_HIGH);

	// shadow of the indirect address, to predict readback
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			idx_r <= 8'h00;
		end else if (wrhit_w && !io_addr_i[0]) begin
			idx_r <= io_wdata_i;
		end
	end

	a_read_answer: assert property (rdhit_w |=> io_rack_o)
		else $error("accepted read got no ack");
	a_no_stray_ack: assert property (io_rack_o |-> $past(rdhit_w))
		else $error("ack without an accepted read");
	a_index_echo: assert property (rd_even_w |=> io_rdata_o == $past(idx_r))
		else $error("even port read lost the index");
	a_refused_read: assert property (rdhit_w && io_addr_i[0] && (idx_r == IDX_GLOBAL_LOAD
		|| idx_r == IDX_GLOBAL_CMD || idx_r > IDX_IRQ_HIGH) |=> io_rdata_o == 8'h00)
		else $error("invalid read returned data");
	a_ctl_write: assert property (wrhit_w && ctl_sel_w |=> irq_ctl_wr_o
		&& irq_ctl_a0_o == $past(idx_r[0]) && irq_ctl_wdata_o == $past(io_wdata_i))
		else $error("controller write wrong");
	a_ctl_wr_cause: assert property (irq_ctl_wr_o |-> $past(wrhit_w))
		else $error("controller write without host write");
	a_ctl_read: assert property (rdhit_w && ctl_sel_w |=> irq_ctl_rd_o && io_rack_o
		&& io_rdata_o == $past(irq_ctl_rdata_i))
		else $error("controller read wrong");
	a_rdata_hold: assert property (!io_rack_o && !$past(sys_rst_i) |-> $stable(io_rdata_o))
		else $error("read data moved without a read");
	a_reset_quiet: assert property ($past(sys_rst_i) |-> !io_rack_o && !irq_ctl_wr_o
		&& !irq_ctl_rd_o && axis_irq_o == 4'h0)
		else $error("outputs active after reset");

	c_ctl_read: cover property (rdhit_w && ctl_sel_w);
	c_even_read: cover property (rd_even_w);
	c_axis_req: cover property (axis_irq_o[0]);
endmodule

bind qec_top qec_asserts u_chk (
	.clk_i,
	.sys_rst_i,
	.io_addr_i,
	.io_wr_i,
	.io_rd_i,
	.io_wdata_i,
	.io_rdata_o,
	.io_rack_o,
	.base_high_nibble_strap_i,
	.base_mid_nibble_switch_i,
	.base_low_nibble_switch_i,
	.irq_ctl_wr_o,
	.irq_ctl_rd_o,
	.irq_ctl_a0_o,
	.irq_ctl_wdata_o,
	.irq_ctl_rdata_i,
	.axis_irq_o
);

// ---- verif/qec_top_tb_top.sv ----
`timescale 1ns/1ps
// ==========================================================
// register-port testbench, board strapped to 300h
module qec_top_tb_top
	import qec_pkg::*;
;
	localparam logic [ADDR_W-1:0] BASE = 12'h300;
	localparam logic [ADDR_W-1:0] DATA = 12'h301;
	logic              clk_i;
	logic              sys_rst_i = 1'b1;
	logic              io_wr_i = 1'b0;
	logic              io_rd_i = 1'b0;
	logic [ADDR_W-1:0] io_addr_i = 12'h000;
	logic [BYTE_W-1:0] io_wdata_i = 8'h00;
	logic [11:0]       enc_in_i = 12'h000;
	logic [2:0]        cascade_strap_i = 3'h0;
	logic [BYTE_W-1:0] io_rdata_o;
	logic              io_rack_o;
	logic              irq_ctl_wr_o;
	logic              irq_ctl_a0_o;
	logic [BYTE_W-1:0] irq_ctl_wdata_o;
	logic [BYTE_W-1:0] irq_ctl_rdata_i;
	logic [AXES-1:0]   axis_irq_o;
	int                n_mismatch = 0;
	int                checked = 0;

	// 20 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	qec_top i_dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
		.io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
		.io_rack_o(io_rack_o), .base_high_nibble_strap_i(1'b1),
		.base_mid_nibble_switch_i(4'h0), .base_low_nibble_switch_i(4'h0),
		.sample_rate_strap_i(3'h0), .cascade_strap_i(cascade_strap_i), .enc_in_i(enc_in_i),
		.irq_ctl_wr_o(irq_ctl_wr_o), .irq_ctl_rd_o(), .irq_ctl_a0_o(irq_ctl_a0_o),
		.irq_ctl_wdata_o(irq_ctl_wdata_o), .irq_ctl_rdata_i(irq_ctl_rdata_i),
		.axis_irq_o(axis_irq_o));

	qec_irqctl_model i_ctl (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wr_i(irq_ctl_wr_o), .a0_i(irq_ctl_a0_o),
		.wdata_i(irq_ctl_wdata_o), .rdata_o(irq_ctl_rdata_i));

	// ==========================================================
	// helpers
	task automatic close_out();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one-cycle strobes, as the port expects
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		io_addr_i  <= a;
		io_wdata_i <= d;
		io_wr_i    <= 1'b1;
		@(posedge clk_i);
		io_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input bit chk);
		@(posedge clk_i);
		io_addr_i <= a;
		io_rd_i   <= 1'b1;
		@(posedge clk_i);
		io_rd_i <= 1'b0;
		#1;
		cmp({7'h00, io_rack_o}, 8'h01, "read ack");
		if (chk)
			cmp(io_rdata_o, e, "read data");
	endtask

	// four setup bytes in their fixed order
	task automatic cmd4(input logic [7:0] m, input logic [7:0] i, input logic [7:0] o,
		input logic [7:0] d);
		wr(DATA, m);
		wr(DATA, i);
		wr(DATA, o);
		wr(DATA, d);
	endtask

	task automatic latch3(input logic [23:0] e);
		wr(BASE, 8'h00);
		rd(DATA, e[7:0], 1'b1);
		rd(DATA, e[15:8], 1'b1);
		rd(DATA, e[23:16], 1'b1);
	endtask

	// hold long enough for the filter at the 10 MHz sample rate
	task automatic step(input int b, input logic v);
		@(posedge clk_i);
		enc_in_i[b] <= v;
		repeat (20) @(posedge clk_i);
	endtask

	// ==========================================================
	// tests
	initial begin
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		wr(BASE, 8'h01);
		rd(BASE, 8'h01, 1'b1);
		rd(DATA, 8'h00, 1'b1);
		wr(12'h302, 8'h07);
		rd(BASE, 8'h01, 1'b1);
		wr(BASE, 8'h00);
		wr(DATA, 8'h12);
		wr(DATA, 8'h34);
		wr(DATA, 8'h56);
		wr(BASE, 8'h01);
		cmd4(8'h04, 8'h00, 8'h40, 8'h02);
		rd(DATA, 8'h04, 1'b1);
		step(0, 1'b1);
		step(0, 1'b0);
		step(0, 1'b1);
		step(0, 1'b0);
		cmd4(8'h01, 8'h00, 8'h40, 8'h02);
		latch3(24'h563414);
		step(1, 1'b1);
		step(1, 1'b0);
		step(1, 1'b1);
		step(1, 1'b0);
		cmp({7'h00, axis_irq_o[0]}, 8'h01, "compare request");
		wr(BASE, 8'h01);
		rd(DATA, 8'h04, 1'b1);
		repeat (3) @(posedge clk_i);
		cmp({7'h00, axis_irq_o[0]}, 8'h00, "request cleared");
		rd(DATA, 8'h00, 1'b1);
		wr(BASE, 8'h00);
		wr(DATA, 8'hd2);
		wr(DATA, 8'h04);
		wr(DATA, 8'h00);
		wr(BASE, 8'h01);
		cmd4(8'h0c, 8'h00, 8'h00, 8'h02);
		cmd4(8'h09, 8'h00, 8'h00, 8'h02);
		latch3(24'h001234);
		wr(BASE, 8'h01);
		cmd4(8'h00, 8'h00, 8'h00, 8'h01);
		step(1, 1'b1);
		step(0, 1'b1);
		step(0, 1'b0);
		step(1, 1'b0);
		cmd4(8'h00, 8'h00, 8'h00, 8'h00);
		step(0, 1'b1);
		step(1, 1'b1);
		step(0, 1'b0);
		step(1, 1'b0);
		cmd4(8'h01, 8'h00, 8'h00, 8'h00);
		latch3(24'h0004d7);
		wr(BASE, 8'h08);
		rd(DATA, 8'h00, 1'b1);
		wr(BASE, 8'h0c);
		rd(DATA, 8'h00, 1'b1);
		wr(BASE, 8'h0a);
		wr(DATA, 8'h5a);
		rd(DATA, 8'h5a, 1'b1);
		wr(BASE, 8'h0b);
		wr(DATA, 8'ha5);
		rd(DATA, 8'ha5, 1'b1);
		wr(BASE, 8'h0a);
		rd(DATA, 8'h5a, 1'b1);
		// chain axis 0 into axis 1, then roll axis 0 over its top value
		cascade_strap_i <= 3'h1;
		wr(BASE, 8'h00);
		wr(DATA, 8'hff);
		wr(DATA, 8'hff);
		wr(DATA, 8'hff);
		wr(BASE, 8'h01);
		cmd4(8'h04, 8'h00, 8'h00, 8'h02);
		step(0, 1'b1);
		step(0, 1'b0);
		wr(BASE, 8'h09);
		cmd4(8'h01, 8'h40, 8'h00, 8'h02);
		wr(BASE, 8'h02);
		rd(DATA, 8'h01, 1'b1);
		wr(BASE, 8'h01);
		rd(DATA, 8'h15, 1'b1);
		// index enabled with load selected: index reloads the counter
		step(2, 1'b1);
		step(2, 1'b0);
		cmd4(8'h01, 8'h40, 8'h00, 8'h02);
		latch3(24'hffffff);
		close_out();
	end

	// the whole run needs about 600 cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		close_out();
	end
endmodule
